// File: rtl/fca_pkg.sv
// Constants and carriers for the floating-point control register access path.
// Assumes one command per clock from the integer core, taken without stall.
package fca_pkg;

  localparam int WORD_W = 32;
  localparam int GPR_W = 64;
  localparam int SEL_W = 5;

  // Control register numbers
  localparam logic [SEL_W-1:0] SEL_IMPL_INFO = 5'h00;
  localparam logic [SEL_W-1:0] SEL_UPPER_VIEW = 5'h19;
  localparam logic [SEL_W-1:0] SEL_CAUSE_FLAG = 5'h1A;
  localparam logic [SEL_W-1:0] SEL_ENABLE_ROUND = 5'h1C;
  localparam logic [SEL_W-1:0] SEL_CONTROL_STATUS = 5'h1F;

  // Control/status field positions
  localparam int CC_HI_MSB = 31;
  localparam int CC_HI_LSB = 25;
  localparam int FLUSH_BIT = 24;
  localparam int CC0_BIT = 23;
  localparam int CAUSE_MSB = 17;
  localparam int CAUSE_LSB = 12;
  localparam int ENABLE_MSB = 11;
  localparam int ENABLE_LSB = 7;
  localparam int INVALID_CAUSE_BIT = 16;
  localparam int INVALID_ENABLE_BIT = 11;
  localparam int INVALID_FLAG_BIT = 6;

  // Field positions inside the views
  localparam int UV_CC_MSB = 7;
  localparam int UV_CC_LSB = 1;
  localparam int UV_CC0_BIT = 0;
  localparam int ER_FLUSH_BIT = 2;
  localparam int UV_PAD_W = 24;

  // Masks of the view fields and of the bits that writes must leave zero
  localparam logic [WORD_W-1:0] MASK_CAUSE_FLAG = 32'h0003_F07C;
  localparam logic [WORD_W-1:0] MASK_ENABLE_ROUND = 32'h0000_0F83;
  localparam logic [WORD_W-1:0] MASK_RESERVED = 32'h007C_0000;
  localparam logic [WORD_W-1:0] MASK_UPPER_HIGH = 32'hFFFF_FF00;

  localparam logic [WORD_W-1:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [WORD_W-1:0] WORD_MAX = 32'h7FFF_FFFF;
  localparam logic [WORD_W-1:0] WORD_MIN = 32'h8000_0000;
  localparam logic [WORD_W-1:0] WORD_ONE = 32'h0000_0001;
  localparam int WORD_MAG_EXP = 30;
  localparam int TRAP_W = 5;

  typedef enum logic [1:0] {
    FCA_OP_MOVE_FROM,
    FCA_OP_MOVE_TO,
    FCA_OP_CEIL
  } fca_op_type;

  typedef struct packed {
    logic valid;
    fca_op_type op;
    logic [SEL_W-1:0] source_reg_select;
    logic [SEL_W-1:0] general_reg_select;
    logic [SEL_W-1:0] dest_fp_select;
    logic [GPR_W-1:0] general_value;
    logic [GPR_W-1:0] floating_value;
    logic fmt_double;
  } fca_cmd_type;

  typedef struct packed {
    logic we;
    logic [SEL_W-1:0] sel;
    logic [GPR_W-1:0] data;
  } fca_gpr_wr_type;

  typedef struct packed {
    logic we;
    logic [SEL_W-1:0] sel;
    logic [WORD_W-1:0] data;
  } fca_fpr_wr_type;

endpackage

// File: rtl/fca_ceil_word.sv
// Ceiling conversion of one floating format to a signed word.
// Assumes a well-formed operand; purely combinational.
`timescale 1ns/100ps
module fca_ceil_word
  import fca_pkg::*;
#(
  parameter int EXP_W = 8,
  parameter int MAN_W = 23
) (
  // Operand
  input wire logic [EXP_W+MAN_W:0] operand,
  // Result
  output logic [WORD_W-1:0] result,
  output logic invalid
);
  localparam int BIAS = (1 << (EXP_W - 1)) - 1;
  localparam logic [EXP_W-1:0] EXP_MAX = '1;

  logic sign;
  logic [EXP_W-1:0] expo;
  logic [MAN_W-1:0] man;

  assign {sign, expo, man} = operand;

  always_comb begin
    int ex;
    logic [63:0] sig;
    logic [63:0] mag;
    logic [63:0] up;
    logic frac;
    ex = int'(expo) - BIAS;
    sig = 64'({1'b1, man});
    mag = '0;
    up = '0;
    frac = 1'b0;
    result = WORD_MAX;
    invalid = 1'b0;
    if (expo == EXP_MAX) begin
      invalid = 1'b1;
    end else if (expo == '0 || ex < 0) begin
      // Below one: rounds up only when positive and nonzero
      result = (!sign && (expo != '0 || man != '0)) ? WORD_ONE : '0;
    end else if (ex > WORD_MAG_EXP + 1) begin
      invalid = 1'b1;
    end else begin
      if (ex <= MAN_W) begin
        mag = sig >> (MAN_W - ex);
        frac = |(sig & ((64'h1 << (MAN_W - ex)) - 64'h1));
      end else begin
        mag = sig << (ex - MAN_W);
      end
      if (sign) begin
        // Truncation is the ceiling for negative values; a fraction
        // below the most negative word still rounds up into range
        if (mag > 64'(WORD_MIN)) begin
          invalid = 1'b1;
        end else begin
          result = 32'(64'h0 - mag);
        end
      end else begin
        up = mag + 64'(frac);
        if (up > 64'(WORD_MAX)) begin
          invalid = 1'b1;
        end else begin
          result = up[WORD_W-1:0];
        end
      end
    end
  end

endmodule

// File: rtl/fca_trap_check.sv
// Pairs cause bits with enable bits into a trap vector.
// Assumes the caller picks old or new fields per view.
`timescale 1ns/100ps
module fca_trap_check
  import fca_pkg::*;
(
  // Fields
  input wire logic [TRAP_W-1:0] cause,
  input wire logic [TRAP_W-1:0] enable,
  // Result
  output logic [TRAP_W-1:0] trap
);
  assign trap = cause & enable;
endmodule

// File: rtl/fca_access.sv
// Floating-point control register access: moves to and from the
// control registers and the ceiling-to-word conversion.
// Assumes the core presents at most one command per clock and takes
// general and floating register writes one cycle after the command.
//
// Operation
// - Ceil converts to signed word, rounding up
// - Unrepresentable ceil sets the invalid flag
// - Enabled invalid: no write, immediate exception
// - Disabled invalid: write maximum positive word
// - Move-from sign-extends selected word into general
// - Register 25 reads condition bits packed low
// - Register 26 reads cause and flags only
// - Register 28 reads enables, flush, rounding
// - Register 31 whole status, 0 info
// - Move-to takes low word of general
// - Full status write traps on cause&enable
// - Update register first, then signal exception
// - View writes trap on newly paired bits
// - Register 25 write loads condition bits
// - Register 26 write loads cause and flags
// - Register 28 write loads enables, flush, rounding
// - Reserved bits zero; 31 replaces whole
`timescale 1ns/100ps
module fca_access
  import fca_pkg::*;
#(
  // Arbitrary value, no meaning beyond identification
  parameter logic [WORD_W-1:0] IMPL_INFO = 32'h00C3_0100
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  // Command from the core
  input wire fca_cmd_type CMD,
  // Register file writes
  output fca_gpr_wr_type GPR_WR,
  output fca_fpr_wr_type FPR_WR,
  // Completion and exceptions
  output logic ACK,
  output logic IGNORED,
  output logic EXC,
  output logic [TRAP_W-1:0] EXC_CAUSE,
  // Current control/status
  output logic [WORD_W-1:0] STATUS
);

  ////////////////////////////////////////////////////////////////////////
  // Command decode

  logic [WORD_W-1:0] status;
  logic [WORD_W-1:0] wval;
  logic is_read;
  logic is_write;
  logic is_ceil;
  logic write_legal;
  logic [WORD_W-1:0] next_status;
  logic [TRAP_W-1:0] trap_cause;
  logic [TRAP_W-1:0] trap_enable;
  logic [TRAP_W-1:0] trap_vec;
  logic [TRAP_W-1:0] exc_pend;
  logic [WORD_W-1:0] read_word;

  assign is_read = CMD.valid && CMD.op == FCA_OP_MOVE_FROM;
  assign is_write = CMD.valid && CMD.op == FCA_OP_MOVE_TO;
  assign is_ceil = CMD.valid && CMD.op == FCA_OP_CEIL;
  assign wval = CMD.general_value[WORD_W-1:0];
  assign STATUS = status;

  ////////////////////////////////////////////////////////////////////////
  // Write merge

  always_comb begin
    next_status = status;
    write_legal = 1'b0;
    trap_cause = '0;
    trap_enable = '0;
    case (CMD.source_reg_select)
      SEL_UPPER_VIEW: begin
        write_legal = (wval & MASK_UPPER_HIGH) == '0;
        next_status[CC_HI_MSB:CC_HI_LSB] = wval[UV_CC_MSB:UV_CC_LSB];
        next_status[CC0_BIT] = wval[UV_CC0_BIT];
      end
      SEL_CAUSE_FLAG: begin
        write_legal = (wval & MASK_RESERVED) == '0;
        next_status = (status & ~MASK_CAUSE_FLAG) | (wval & MASK_CAUSE_FLAG);
        trap_cause = wval[CAUSE_MSB-1:CAUSE_LSB];
        trap_enable = status[ENABLE_MSB:ENABLE_LSB];
      end
      SEL_ENABLE_ROUND: begin
        write_legal = (wval & MASK_RESERVED) == '0;
        next_status = (status & ~MASK_ENABLE_ROUND) | (wval & MASK_ENABLE_ROUND);
        next_status[FLUSH_BIT] = wval[ER_FLUSH_BIT];
        trap_cause = status[CAUSE_MSB-1:CAUSE_LSB];
        trap_enable = wval[ENABLE_MSB:ENABLE_LSB];
      end
      SEL_CONTROL_STATUS: begin
        write_legal = (wval & MASK_RESERVED) == '0;
        next_status = wval;
        trap_cause = wval[CAUSE_MSB-1:CAUSE_LSB];
        trap_enable = wval[ENABLE_MSB:ENABLE_LSB];
      end
      default: begin
        write_legal = 1'b0;
      end
    endcase
  end

  fca_trap_check u_trap (
    .cause(trap_cause),
    .enable(trap_enable),
    .trap(trap_vec)
  );

  ////////////////////////////////////////////////////////////////////////
  // Ceiling conversion

  logic [WORD_W-1:0] ceil_single;
  logic [WORD_W-1:0] ceil_double;
  logic inv_single;
  logic inv_double;
  logic [WORD_W-1:0] ceil_result;
  logic ceil_invalid;
  logic ceil_trap;
  // Invalid-operation position in the trap vector
  localparam logic [TRAP_W-1:0] TRAP_INVALID = TRAP_W'(1) << (INVALID_CAUSE_BIT - CAUSE_LSB);

  fca_ceil_word #(.EXP_W(8), .MAN_W(23)) u_ceil_s (
    .operand(CMD.floating_value[WORD_W-1:0]),
    .result(ceil_single),
    .invalid(inv_single)
  );

  fca_ceil_word #(.EXP_W(11), .MAN_W(52)) u_ceil_d (
    .operand(CMD.floating_value),
    .result(ceil_double),
    .invalid(inv_double)
  );

  assign ceil_result = CMD.fmt_double ? ceil_double : ceil_single;
  assign ceil_invalid = CMD.fmt_double ? inv_double : inv_single;
  assign ceil_trap = is_ceil && ceil_invalid && status[INVALID_ENABLE_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Read views

  always_comb begin
    case (CMD.source_reg_select)
      SEL_IMPL_INFO: read_word = IMPL_INFO;
      SEL_CONTROL_STATUS: read_word = status;
      SEL_UPPER_VIEW: read_word = {{UV_PAD_W{1'b0}}, status[CC_HI_MSB:CC_HI_LSB], status[CC0_BIT]};
      SEL_CAUSE_FLAG: read_word = status & MASK_CAUSE_FLAG;
      SEL_ENABLE_ROUND: begin
        read_word = status & MASK_ENABLE_ROUND;
        read_word[ER_FLUSH_BIT] = status[FLUSH_BIT];
      end
      default: read_word = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Status register

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      status <= STATUS_RESET;
    end else if (is_write && write_legal) begin
      status <= next_status;
    end else if (is_ceil && ceil_invalid) begin
      status[INVALID_CAUSE_BIT] <= 1'b1;
      status[INVALID_FLAG_BIT] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register file writes

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      GPR_WR <= '0;
    end else begin
      GPR_WR.we <= is_read;
      GPR_WR.sel <= CMD.general_reg_select;
      GPR_WR.data <= {{(GPR_W - WORD_W){read_word[WORD_W-1]}}, read_word};
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      FPR_WR <= '0;
    end else begin
      FPR_WR.we <= is_ceil && !ceil_trap;
      FPR_WR.sel <= CMD.dest_fp_select;
      FPR_WR.data <= ceil_invalid ? WORD_MAX : ceil_result;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Completion and exceptions

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ACK <= 1'b0;
      IGNORED <= 1'b0;
    end else begin
      ACK <= CMD.valid;
      IGNORED <= is_write && !write_legal;
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      exc_pend <= '0;
    end else begin
      exc_pend <= (is_write && write_legal) ? trap_vec : '0;
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      EXC <= 1'b0;
      EXC_CAUSE <= '0;
    end else begin
      EXC <= (|exc_pend) || ceil_trap;
      EXC_CAUSE <= exc_pend | (ceil_trap ? TRAP_INVALID : '0);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  logic legal_wr;
  assign legal_wr = is_write && write_legal;

  a_ceil_flag: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    is_ceil && ceil_invalid && !is_write |=> status[INVALID_FLAG_BIT] && status[INVALID_CAUSE_BIT])
    else $error("invalid conversion left flag clear");

  a_ceil_trap: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    ceil_trap |=> !FPR_WR.we && EXC && EXC_CAUSE[TRAP_W-1])
    else $error("trapping conversion wrote or did not trap");

  a_ceil_default: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    is_ceil && ceil_invalid && !status[INVALID_ENABLE_BIT] |=> FPR_WR.we && FPR_WR.data == WORD_MAX)
    else $error("default result missing");

  a_ceil_sign: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    is_ceil && !ceil_invalid && CMD.floating_value[GPR_W-1] && CMD.fmt_double
    |=> FPR_WR.we && (FPR_WR.data[WORD_W-1] || FPR_WR.data == '0))
    else $error("negative source gave positive word");

  a_sign_extend: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    GPR_WR.we |-> GPR_WR.data[GPR_W-1:WORD_W] == {(GPR_W - WORD_W){GPR_WR.data[WORD_W-1]}})
    else $error("general write not sign extended");

  a_read_upper: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    is_read && CMD.source_reg_select == SEL_UPPER_VIEW
    |=> GPR_WR.data[WORD_W-1:UV_CC_MSB+1] == '0 && GPR_WR.data[UV_CC_MSB:UV_CC_LSB] == status[CC_HI_MSB:CC_HI_LSB]
        && GPR_WR.data[UV_CC0_BIT] == status[CC0_BIT])
    else $error("upper view read wrong");

  a_read_enable: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    is_read && CMD.source_reg_select == SEL_ENABLE_ROUND
    |=> GPR_WR.data[ER_FLUSH_BIT] == status[FLUSH_BIT]
        && (GPR_WR.data[WORD_W-1:0] & ~MASK_ENABLE_ROUND & ~(WORD_W'(1) << ER_FLUSH_BIT)) == '0)
    else $error("enable view read wrong");

  a_read_whole: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    is_read && CMD.source_reg_select == SEL_CONTROL_STATUS |=> GPR_WR.data[WORD_W-1:0] == status)
    else $error("status read differs");

  a_write_whole: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    legal_wr && CMD.source_reg_select == SEL_CONTROL_STATUS |=> status == $past(wval))
    else $error("status write not stored");

  a_view_merge: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    legal_wr && CMD.source_reg_select == SEL_CAUSE_FLAG
    |=> (status & ~MASK_CAUSE_FLAG) == $past(status & ~MASK_CAUSE_FLAG)
        && (status & MASK_CAUSE_FLAG) == $past(wval & MASK_CAUSE_FLAG))
    else $error("cause view merge wrong");

  a_exc_order: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    legal_wr && trap_vec != '0 |=> exc_pend == $past(trap_vec) ##1 EXC)
    else $error("write exception not raised after update");

  a_bad_write: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    is_write && !write_legal |=> $stable(status) && IGNORED && exc_pend == '0)
    else $error("illegal write had an effect");

  a_read_cause: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    is_read && CMD.source_reg_select == SEL_CAUSE_FLAG
    |=> GPR_WR.data[WORD_W-1:0] == (status & MASK_CAUSE_FLAG))
    else $error("cause view read wrong");

  a_read_info: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    is_read && CMD.source_reg_select == SEL_IMPL_INFO |=> GPR_WR.data[WORD_W-1:0] == IMPL_INFO)
    else $error("information read wrong");

  a_upper_merge: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    legal_wr && CMD.source_reg_select == SEL_UPPER_VIEW
    |=> status[CC_HI_MSB:CC_HI_LSB] == $past(wval[UV_CC_MSB:UV_CC_LSB])
        && status[CC0_BIT] == $past(wval[UV_CC0_BIT]) && status[FLUSH_BIT] == $past(status[FLUSH_BIT])
        && status[CC0_BIT-1:0] == $past(status[CC0_BIT-1:0]))
    else $error("upper view merge wrong");

  a_enable_merge: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    legal_wr && CMD.source_reg_select == SEL_ENABLE_ROUND
    |=> status[ENABLE_MSB:ENABLE_LSB] == $past(wval[ENABLE_MSB:ENABLE_LSB])
        && status[FLUSH_BIT] == $past(wval[ER_FLUSH_BIT])
        && status[CAUSE_MSB:CAUSE_LSB] == $past(status[CAUSE_MSB:CAUSE_LSB]))
    else $error("enable view merge wrong");

  a_status_trap: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    legal_wr && CMD.source_reg_select == SEL_CONTROL_STATUS
    && (wval[CAUSE_MSB-1:CAUSE_LSB] & wval[ENABLE_MSB:ENABLE_LSB]) != '0 |-> ##2 EXC)
    else $error("status write pair raised nothing");

  a_view_trap: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    legal_wr && CMD.source_reg_select == SEL_CAUSE_FLAG
    && (wval[CAUSE_MSB-1:CAUSE_LSB] & status[ENABLE_MSB:ENABLE_LSB]) != '0 |-> ##2 EXC)
    else $error("cause view pair raised nothing");

  c_ceil_trap: cover property (@(posedge REF_CLK) disable iff (SYS_RST) ceil_trap ##1 EXC);
  c_ceil_default: cover property (@(posedge REF_CLK) disable iff (SYS_RST)
    is_ceil && ceil_invalid && !status[INVALID_ENABLE_BIT]);
  c_write_trap: cover property (@(posedge REF_CLK) disable iff (SYS_RST) legal_wr && trap_vec != '0 ##2 EXC);
  c_read_view: cover property (@(posedge REF_CLK) disable iff (SYS_RST)
    is_read && CMD.source_reg_select == SEL_ENABLE_ROUND);

endmodule

// File: tb/fca_core_model.sv
// Integer core register file model: stores what the access path writes back.
// Assumes writes come as one-cycle strobes on the processor clock.
`timescale 1ns/100ps
module fca_core_model
  import fca_pkg::*;
(
  // Clock
  input wire logic clk,
  // Write ports
  input wire fca_gpr_wr_type gpr_wr,
  input wire fca_fpr_wr_type fpr_wr
);
  logic [GPR_W-1:0] general_register [32];
  logic [WORD_W-1:0] floating_register [32];

  // Whole doubleword kept, so lost sign extension shows
  always_ff @(posedge clk) begin
    if (gpr_wr.we) begin
      general_register[gpr_wr.sel] <= gpr_wr.data;
    end
  end

  always_ff @(posedge clk) begin
    if (fpr_wr.we) begin
      floating_register[fpr_wr.sel] <= fpr_wr.data;
    end
  end
endmodule

// File: tb/tb.sv
// Self-checking bench for the control register access path.
// Assumes one command at a time, driven on the falling edge.
`timescale 1ns/100ps
module tb;
  import fca_pkg::*;
  // Arbitrary value
  localparam logic [WORD_W-1:0] IMPL = 32'h0012_3400;
  logic clk;
  logic rst;
  fca_cmd_type cmd;
  fca_gpr_wr_type gpr_wr;
  fca_fpr_wr_type fpr_wr;
  logic ack, ignored, exc, r_ack, r_ign, r_exc1, r_exc2, r_gwe, r_fwe;
  logic [TRAP_W-1:0] exc_cause, r_cause1, r_cause2;
  logic [WORD_W-1:0] status, r_status, r_fdata;
  logic [WORD_W-1:0] exp_status = 32'h0000_0000;
  logic [GPR_W-1:0] r_gdata;
  int miscompares = 0;
  int n_compared = 0;
  logic [SEL_W-1:0] wsel [13] = '{5'h1F, 5'h1F, 5'h1C, 5'h1A, 5'h1A, 5'h19, 5'h1F,
                                  5'h19, 5'h1A, 5'h1C, 5'h1F, 5'h03, 5'h00};
  logic [WORD_W-1:0] wval [13] = '{32'h0000_0000, 32'hFF83_F07F, 32'h0000_0F87, 32'h0000_0000,
                                   32'h0001_0040, 32'h0000_00AB, 32'h0000_1080, 32'h0000_0100,
                                   32'h0004_0000, 32'h0040_0000, 32'h0010_1080, 32'h0000_0000,
                                   32'hFFFF_FFFF};
  // Top bit selects double format / marks an invalid conversion
  logic [64:0] ceil_in [14] = '{{1'b0, 64'h3FC0_0000}, {1'b0, 64'hBFC0_0000}, {1'b0, 64'h3E80_0000},
                                {1'b0, 64'hBF00_0000}, {1'b0, 64'h7F80_0000}, {1'b0, 64'h7FC0_0000},
                                {1'b0, 64'h4F00_0000}, {1'b0, 64'hCF00_0000}, {1'b0, 64'hFF80_0000},
                                {1'b1, 64'h4004_0000_0000_0000}, {1'b1, 64'h41DF_FFFF_FFE0_0000},
                                {1'b1, 64'h41DF_FFFF_FFA0_0000}, {1'b1, 64'hC1E0_0000_0010_0000},
                                {1'b1, 64'hC1E0_0000_0020_0000}};
  logic [32:0] ceil_out [14] = '{{1'b0, 32'h0000_0002}, {1'b0, 32'hFFFF_FFFF}, {1'b0, 32'h0000_0001},
                                 {1'b0, 32'h0000_0000}, {1'b1, 32'h7FFF_FFFF}, {1'b1, 32'h7FFF_FFFF},
                                 {1'b1, 32'h7FFF_FFFF}, {1'b0, 32'h8000_0000}, {1'b1, 32'h7FFF_FFFF},
                                 {1'b0, 32'h0000_0003}, {1'b1, 32'h7FFF_FFFF}, {1'b0, 32'h7FFF_FFFF},
                                 {1'b0, 32'h8000_0000}, {1'b1, 32'h7FFF_FFFF}};

  fca_access #(.IMPL_INFO(IMPL)) u_fca_access (.REF_CLK(clk), .SYS_RST(rst), .CMD(cmd), .GPR_WR(gpr_wr),
    .FPR_WR(fpr_wr), .ACK(ack), .IGNORED(ignored), .EXC(exc), .EXC_CAUSE(exc_cause), .STATUS(status));
  fca_core_model u_fca_core_model (.clk(clk), .gpr_wr(gpr_wr), .fpr_wr(fpr_wr));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [GPR_W-1:0] exp, input logic [GPR_W-1:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One command; samples the answer cycle and the cycle after
  task automatic issue(input fca_op_type op, input logic [SEL_W-1:0] sel, input logic [GPR_W-1:0] v,
      input logic dbl);
    cmd = '{valid: 1'b1, op: op, source_reg_select: sel, general_reg_select: sel, dest_fp_select: sel,
            general_value: v, floating_value: v, fmt_double: dbl};
    @(posedge clk);
    @(negedge clk);
    {r_ack, r_ign, r_exc1, r_cause1, r_status} = {ack, ignored, exc, exc_cause, status};
    {r_gwe, r_gdata, r_fwe, r_fdata} = {gpr_wr.we, gpr_wr.data, fpr_wr.we, fpr_wr.data};
    cmd.valid = 1'b0;
    @(posedge clk);
    @(negedge clk);
    {r_exc2, r_cause2} = {exc, exc_cause};
    chk("ack", 1, r_ack);
  endtask

  function automatic logic [WORD_W-1:0] view(input logic [SEL_W-1:0] sel, input logic [WORD_W-1:0] s);
    case (sel)
      5'h00: view = IMPL;
      5'h19: view = {24'h0, s[31:25], s[23]};
      5'h1A: view = s & 32'h0003_F07C;
      5'h1C: view = {20'h0, s[11:7], 4'h0, s[24], s[1:0]};
      5'h1F: view = s;
      default: view = 32'h0;
    endcase
  endfunction

  task automatic read_all();
    logic [SEL_W-1:0] sels [6] = '{5'h00, 5'h19, 5'h1A, 5'h1C, 5'h1F, 5'h05};
    logic [WORD_W-1:0] e;
    foreach (sels[i]) begin
      e = view(sels[i], exp_status);
      issue(FCA_OP_MOVE_FROM, sels[i], 64'h0, 1'b0);
      chk("read_we", 1, r_gwe);
      chk("read_data", {{32{e[31]}}, e}, r_gdata);
      chk("core_reg", {{32{e[31]}}, e}, u_fca_core_model.general_register[sels[i]]);
    end
  endtask

  task automatic write_case(input logic [SEL_W-1:0] sel, input logic [WORD_W-1:0] v);
    logic legal;
    logic [TRAP_W-1:0] trap;
    logic [WORD_W-1:0] s;
    s = exp_status;
    legal = (v[22:18] == 5'h0);
    trap = 5'h00;
    case (sel)
      5'h19: begin
        legal = (v[31:8] == 24'h0);
        s = {v[7:1], s[24], v[0], s[22:0]};
      end
      5'h1A: begin
        trap = v[16:12] & s[11:7];
        s = {s[31:18], v[17:12], s[11:7], v[6:2], s[1:0]};
      end
      5'h1C: begin
        trap = s[16:12] & v[11:7];
        s = {s[31:25], v[2], s[23:12], v[11:7], s[6:2], v[1:0]};
      end
      5'h1F: begin
        trap = v[16:12] & v[11:7];
        s = v;
      end
      default: legal = 1'b0;
    endcase
    if (legal) begin
      exp_status = s;
    end else begin
      trap = 5'h00;
    end
    issue(FCA_OP_MOVE_TO, sel, {32'hA5A5_A5A5, v}, 1'b0);
    chk("status", exp_status, r_status);
    chk("ignored", !legal, r_ign);
    chk("exc_early", 0, r_exc1);
    chk("exc", trap != 5'h00, r_exc2);
    chk("exc_cause", trap, r_cause2);
  endtask

  task automatic ceil_case(input int k, input logic en);
    logic bad;
    bad = ceil_out[k][32];
    write_case(SEL_CONTROL_STATUS, {20'h0, en, 11'h0});
    issue(FCA_OP_CEIL, 5'(k), ceil_in[k][63:0], ceil_in[k][64]);
    if (bad) begin
      exp_status = exp_status | 32'h0001_0040;
    end
    chk("ceil_status", exp_status, r_status);
    chk("ceil_we", !(bad && en), r_fwe);
    if (!(bad && en)) begin
      chk("ceil_data", ceil_out[k][31:0], r_fdata);
      chk("core_fpr", ceil_out[k][31:0], u_fca_core_model.floating_register[k]);
    end
    chk("ceil_exc", bad && en, r_exc1);
    chk("ceil_cause", (bad && en) ? 5'h10 : 5'h00, r_cause1);
  endtask

  task automatic test_done();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    cmd = '0;
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    chk("status_reset", 32'h0, status);
    read_all();
    $display("test reset_views done");
    // Reserved-bit cases stand on purpose beside legal ones
    foreach (wsel[i]) begin
      write_case(wsel[i], wval[i]);
      read_all();
    end
    $display("test control_writes done");
    for (int e = 0; e < 2; e++) begin
      foreach (ceil_in[k]) begin
        ceil_case(k, e[0]);
      end
    end
    $display("test ceil done");
    // Mid-run reset must bring the status back to its reset value
    rst = 1'b1;
    @(negedge clk);
    chk("status_rerun", 32'h0, status);
    rst = 1'b0;
    exp_status = 32'h0;
    read_all();
    $display("test mid_reset done");
    test_done();
  end

  // Run needs under 600 cycles
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    $display("watchdog expired");
    test_done();
  end
endmodule
